// ==== nipc_ctrl.sv ====
// Nested interrupt priority controller: level pair, vector priorities,
// arbitration and entry sequencing.
// Assumes peripherals hold their requests until serviced or cleared, and
// the CPU strobes retired instructions on pclk.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

module nipc_ctrl
  import nipc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [nipc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [nipc_pkg::NUM_VEC-1:0] irq_req,
  input wire nipc_pkg::nipc_instr_t cpu_instr,
  input wire logic instr_boundary,
  input wire logic stack_done,
  input wire nipc_pkg::nipc_mode_t halt_mode,
  output nipc_pkg::nipc_entry_t entry,
  output logic [1:0] cc_prio,
  output logic branch_if_masked,
  output logic branch_if_unmasked,
  output logic wake
);
  import nipc_pkg::*;

  // Last entry is the spare pair: stored and read back, never arbitrated
  logic [1:0] vec_lvl [NUM_VEC + 1];
  nipc_state_t state;
  logic trap_pend;
  logic serve_nmi;
  logic [3:0] serve_num;
  logic [1:0] serve_lvl;

  logic apb_done;
  logic apb_wr;
  logic [31:0] next_prdata;
  logic next_err;

  logic [12:0] wake_mask;
  logic [12:0] eligible;
  logic win_valid;
  logic [3:0] win_num;
  logic [1:0] win_rank;

  // APB: one wait state, write and read take effect on the pready edge
  assign apb_done = psel && penable && pready;
  assign apb_wr = apb_done && pwrite && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_err;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Read mux; the top nibble of the fourth register always reads ones
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == OFS_LEVEL0) begin
      next_prdata[7:0] = {vec_lvl[3], vec_lvl[2], vec_lvl[1], vec_lvl[0]};
    end else if (paddr == OFS_LEVEL1) begin
      next_prdata[7:0] = {vec_lvl[7], vec_lvl[6], vec_lvl[5], vec_lvl[4]};
    end else if (paddr == OFS_LEVEL2) begin
      next_prdata[7:0] = {vec_lvl[11], vec_lvl[10], vec_lvl[9], vec_lvl[8]};
    end else if (paddr == OFS_LEVEL3) begin
      next_prdata[7:0] = {LEVEL3_RO_ONES, vec_lvl[NUM_VEC],
                          vec_lvl[NUM_VEC-1]};
    end else if (paddr == OFS_CC) begin
      next_prdata[CC_HI_POS] = cc_prio[1];
      next_prdata[CC_LO_POS] = cc_prio[0];
    end else if (paddr == OFS_PEND) begin
      next_prdata[NUM_VEC-1:0] = irq_req;
    end else begin
      next_err = 1'b1;
    end
  end

  // Vector level pairs; pair i sits at bits 2*(i%4) of register i/4
  genvar gi;
  generate
    for (gi = 0; gi <= NUM_VEC; gi++) begin : g_vec
      localparam logic [7:0] REG_OFS = 8'((gi / 4) * 4);
      localparam int BIT_POS = (gi % 4) * 2;
      logic [1:0] wr_pair;
      assign wr_pair = pwdata[BIT_POS +: 2];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          vec_lvl[gi] <= LEVEL_RESET[BIT_POS +: 2];
        end else if (apb_wr && paddr == REG_OFS) begin
          // Level 0 pattern is refused per pair only
          if (wr_pair != LVL0) begin
            vec_lvl[gi] <= wr_pair;
          end
        end
      end
    end
  endgenerate

  // Wake capability depends on which halt flavour the CPU is in
  always_comb begin
    case (halt_mode)
      MODE_HALT: wake_mask = WAKE_HALT;
      MODE_ACTIVE_HALT: wake_mask = WAKE_ACTIVE;
      MODE_AUTO_WAKEUP: wake_mask = WAKE_AUTO;
      default: wake_mask = USED_MASK;
    endcase
  end

  // Ranks run 10, 01, 00, 11 upward, so 00 sits above 01
  // Reserved vectors never compete in halt only wakers compete
  always_comb begin
    for (int i = 0; i < NUM_VEC; i++) begin
      eligible[i] = irq_req[i] && USED_MASK[i] && wake_mask[i] &&
                    (lvl_rank(vec_lvl[i]) > lvl_rank(cc_prio));
    end
  end

  // Scan from lowest hardware priority up so the lower index wins ties
  always_comb begin
    win_valid = 1'b0;
    win_num = 4'h0;
    win_rank = 2'd0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (eligible[i] &&
          (!win_valid || lvl_rank(vec_lvl[i]) >= win_rank)) begin
        win_valid = 1'b1;
        win_num = 4'(i);
        win_rank = lvl_rank(vec_lvl[i]);
      end
    end
  end

  // Trap strobe is held until its entry starts; a new strobe wins the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_pend <= 1'b0;
    end else if (cpu_instr.trap_instr) begin
      trap_pend <= 1'b1;
    end else if (state == ST_IDLE && instr_boundary) begin
      trap_pend <= 1'b0;
    end
  end

  // Entry sequencer: boundary, stack, then vector and level load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      serve_nmi <= 1'b0;
      serve_num <= 4'h0;
      serve_lvl <= LVL3;
    end else begin
      case (state)
        ST_IDLE: begin
          // Trap ignores the current level
          if (instr_boundary && trap_pend) begin
            state <= ST_STACK;
            serve_nmi <= 1'b1;
            serve_lvl <= LVL3;
          end else if (instr_boundary && win_valid) begin
            state <= ST_STACK;
            serve_nmi <= 1'b0;
            serve_num <= win_num;
            serve_lvl <= vec_lvl[win_num];
          end
        end
        ST_STACK: begin
          if (stack_done) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pulses toward the CPU; reset leaves the reset vector on the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry.stack_req <= 1'b0;
      entry.enter <= 1'b0;
      entry.nmi <= 1'b1;
      entry.vec_num <= 4'h0;
      entry.vec_addr <= VEC_RESET;
    end else begin
      entry.stack_req <= state == ST_IDLE && instr_boundary &&
                         (trap_pend || win_valid);
      entry.enter <= state == ST_LOAD;
      if (state == ST_LOAD) begin
        entry.nmi <= serve_nmi;
        entry.vec_num <= serve_num;
        // Two bytes per vector, descending from vector 0
        entry.vec_addr <= serve_nmi ? VEC_TRAP :
                          VEC_BASE - {11'h000, serve_num, 1'b0};
      end
    end
  end

  // Current level pair; entry load has priority over retiring instructions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_prio <= LVL3;
    end else if (state == ST_LOAD) begin
      // A raised level of the serviced vector acts at its next entry
      cc_prio <= serve_lvl;
    end else if (cpu_instr.irq_return_instr || cpu_instr.pop_cc_instr) begin
      cc_prio <= {cpu_instr.cc_data[CC_HI_POS],
                  cpu_instr.cc_data[CC_LO_POS]};
    end else if (cpu_instr.disable_irq_instr) begin
      cc_prio <= LVL3;
    end else if (cpu_instr.enable_irq_instr || cpu_instr.halt_instr ||
                 cpu_instr.wait_for_irq_instr) begin
      cc_prio <= LVL0;
    end
  end

  // Branch conditions follow the pair one cycle late, from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch_if_masked <= 1'b1;
      branch_if_unmasked <= 1'b0;
    end else begin
      branch_if_masked <= cc_prio == LVL3;
      branch_if_unmasked <= cc_prio != LVL3;
    end
  end

  // Wake request while halted: a wake-capable source is eligible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake <= 1'b0;
    end else begin
      wake <= halt_mode != MODE_RUN && win_valid;
    end
  end

endmodule // nipc_ctrl

// ==== nipc_pkg.sv ====
// Shared constants and types of the nested interrupt priority controller.
// Assumes an APB master and a CPU core on the same pclk.
package nipc_pkg;

  localparam int NUM_VEC = 13;
  localparam int APB_AW = 8;

  // Register byte offsets on APB
  localparam logic [7:0] OFS_LEVEL0 = 8'h00;
  localparam logic [7:0] OFS_LEVEL1 = 8'h04;
  localparam logic [7:0] OFS_LEVEL2 = 8'h08;
  localparam logic [7:0] OFS_LEVEL3 = 8'h0C;
  localparam logic [7:0] OFS_CC = 8'h10;
  localparam logic [7:0] OFS_PEND = 8'h14;

  localparam logic [7:0] LEVEL_RESET = 8'hFF;
  localparam logic [3:0] LEVEL3_RO_ONES = 4'hF;

  // Level encodings of a {hi, lo} pair
  localparam logic [1:0] LVL0 = 2'b10;
  localparam logic [1:0] LVL1 = 2'b01;
  localparam logic [1:0] LVL2 = 2'b00;
  localparam logic [1:0] LVL3 = 2'b11;

  // Positions of the pair in the condition code
  localparam int CC_HI_POS = 5;
  localparam int CC_LO_POS = 3;

  // Vector table
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_BASE = 16'hFFFA;

  // Vector 1 is reserved
  localparam logic [12:0] USED_MASK = 13'h1FFD;
  // Wake capability per halt flavour
  localparam logic [12:0] WAKE_HALT = 13'h001C;
  localparam logic [12:0] WAKE_ACTIVE = 13'h049C;
  localparam logic [12:0] WAKE_AUTO = 13'h001D;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_HALT = 2'b01,
    MODE_ACTIVE_HALT = 2'b10,
    MODE_AUTO_WAKEUP = 2'b11
  } nipc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STACK = 2'b01,
    ST_LOAD = 2'b11
  } nipc_state_t;

  // Level-changing instructions retired by the CPU, one-cycle strobes
  typedef struct packed {
    logic enable_irq_instr;
    logic disable_irq_instr;
    logic halt_instr;
    logic wait_for_irq_instr;
    logic pop_cc_instr;
    logic irq_return_instr;
    logic trap_instr;
    logic [7:0] cc_data;
  } nipc_instr_t;

  // Entry sequence toward the CPU
  typedef struct packed {
    logic stack_req;
    logic enter;
    logic nmi;
    logic [3:0] vec_num;
    logic [15:0] vec_addr;
  } nipc_entry_t;

  // Ordering rank of an encoded level
  function automatic logic [1:0] lvl_rank(input logic [1:0] p);
    case (p)
      LVL0: lvl_rank = 2'd0;
      LVL1: lvl_rank = 2'd1;
      LVL2: lvl_rank = 2'd2;
      default: lvl_rank = 2'd3;
    endcase
  endfunction

endpackage

// ==== nipc_ctrl_monitor.sv ====
// Port checker of the interrupt priority controller.
// Assumes binding to nipc_ctrl; one pclk domain.
`timescale 1ns/1ps
module nipc_ctrl_monitor
  import nipc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [nipc_pkg::NUM_VEC-1:0] irq_req,
  input wire nipc_pkg::nipc_instr_t cpu_instr,
  input wire logic stack_done,
  input wire nipc_pkg::nipc_mode_t halt_mode,
  input wire nipc_pkg::nipc_entry_t entry,
  input wire logic [1:0] cc_prio,
  input wire logic branch_if_masked,
  input wire logic branch_if_unmasked,
  input wire logic wake
);
  logic [1:0] cc_pair;
  assign cc_pair = {cpu_instr.cc_data[CC_HI_POS],
                    cpu_instr.cc_data[CC_LO_POS]};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_stacked;
    entry.stack_req ##[0:40] stack_done;
  endsequence
  chk_stack_then_enter: assert property (
    s_stacked |-> ##2 entry.enter) else $error("enter late after stack");
  chk_no_early_enter: assert property (
    entry.enter |-> $past(stack_done, 2)) else $error("enter before stack");
  chk_enable_level: assert property (
    (cpu_instr.enable_irq_instr || cpu_instr.halt_instr ||
     cpu_instr.wait_for_irq_instr) && !cpu_instr.disable_irq_instr &&
    !cpu_instr.pop_cc_instr && !cpu_instr.irq_return_instr
    |=> entry.enter || cc_prio == LVL0) else $error("level 0 not loaded");
  chk_disable_level: assert property (
    cpu_instr.disable_irq_instr && !cpu_instr.pop_cc_instr &&
    !cpu_instr.irq_return_instr
    |=> entry.enter || cc_prio == LVL3) else $error("level 3 not loaded");
  chk_pop_restores: assert property (
    cpu_instr.irq_return_instr || cpu_instr.pop_cc_instr
    |=> entry.enter || cc_prio == $past(cc_pair)) else $error("pop level");
  chk_branch_follow: assert property (
    presetn |-> branch_if_masked == ($past(cc_prio) == LVL3) &&
    branch_if_unmasked != branch_if_masked) else $error("branch flags");
  chk_nmi_masks: assert property (
    entry.enter && entry.nmi |-> cc_prio == LVL3) else $error("nmi level");
  chk_vector_addr: assert property (
    entry.enter && !entry.nmi |-> entry.vec_num != 4'h1 &&
    entry.vec_num <= 4'hC &&
    entry.vec_addr == VEC_BASE - {11'h000, entry.vec_num, 1'b0})
    else $error("vector address");
  chk_halt_wake: assert property (
    wake && $past(halt_mode) == MODE_HALT
    |-> ($past(irq_req) & WAKE_HALT) != 13'h0000) else $error("halt wake");
  chk_auto_wakeup: assert property (
    wake && $past(halt_mode) == MODE_AUTO_WAKEUP
    |-> ($past(irq_req) & WAKE_AUTO) != 13'h0000)
    else $error("auto wakeup wake");
endmodule // nipc_ctrl_monitor

bind nipc_ctrl nipc_ctrl_monitor i_nipc_ctrl_monitor (
  .pclk, .presetn, .irq_req, .cpu_instr, .stack_done, .halt_mode,
  .entry, .cc_prio, .branch_if_masked, .branch_if_unmasked, .wake
);

// ==== nipc_cpu_model.sv ====
// CPU core stand-in that stacks context when asked.
// Assumes stack_req pulses once per entry; delay set by the bench.
`timescale 1ns/1ps
module nipc_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stack_req,
  input wire logic [3:0] stack_cycles,
  output logic stack_done
);
  logic [3:0] cnt;
  logic busy;
  // Counts down from stack_cycles, then reports once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      stack_done <= 1'b0;
    end else begin
      stack_done <= busy && cnt == 4'h0;
      if (stack_req) begin
        busy <= 1'b1;
        cnt <= stack_cycles;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // nipc_cpu_model

// ==== nested_interrupt_priority_ctrl_tb.sv ====
// Self-checking bench of the interrupt priority controller.
// Assumes the CPU model on entry and an APB master on pclk.
`timescale 1ns/1ps
module nested_interrupt_priority_ctrl_tb;
  import nipc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, last_err, stack_done, wake;
  logic [12:0] irq_req = 13'h0000;
  nipc_instr_t cpu_instr = '0;
  logic instr_boundary = 1'b0;
  nipc_mode_t halt_mode = MODE_RUN;
  nipc_entry_t entry;
  logic [1:0] cc_prio;
  logic branch_if_masked, branch_if_unmasked;
  logic [3:0] stack_cycles = 4'h0;
  int miscompares = 0;
  int checks_done = 0;

  nipc_ctrl i_nipc_ctrl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .irq_req, .cpu_instr, .instr_boundary,
    .stack_done, .halt_mode, .entry, .cc_prio, .branch_if_masked,
    .branch_if_unmasked, .wake
  );
  nipc_cpu_model i_nipc_cpu_model (
    .pclk, .presetn, .stack_req(entry.stack_req), .stack_cycles, .stack_done
  );

  initial forever #5 pclk = ~pclk;

  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    summarize();
  endtask
  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) timeout();
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    cmp($sformatf("reg %h", a), exp, r);
  endtask
  // Op bits: enable, disable, halt, wait, pop, return, trap
  task automatic pulse(input logic [6:0] op, input logic [7:0] cc);
    @(posedge pclk);
    cpu_instr <= {op, cc};
    @(posedge pclk);
    cpu_instr <= '0;
  endtask
  task automatic step(input logic [6:0] op, input logic [7:0] cc,
      input logic [1:0] lvl);
    pulse(op, cc);
    repeat (3) @(posedge pclk);
    cmp("level", 32'(lvl), 32'(cc_prio));
    cmp("branch", {30'h0000_0000, lvl == LVL3, lvl != LVL3},
        {30'h0000_0000, branch_if_masked, branch_if_unmasked});
  endtask
  task automatic wait_enter(input logic [15:0] addr, input logic [1:0] lvl);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (entry.enter !== 1'b1 && n < 64);
    if (n >= 64) timeout();
    cmp("vector", 32'(addr), 32'(entry.vec_addr));
    cmp("nmi", 32'(addr == VEC_TRAP), 32'(entry.nmi));
    cmp("level", 32'(lvl), 32'(cc_prio));
  endtask
  task automatic quiet(input logic [12:0] req);
    int hits;
    hits = 0;
    irq_req <= req;
    repeat (20) begin
      @(posedge pclk);
      hits += int'(entry.stack_req === 1'b1);
    end
    cmp("no entry", 32'h0000_0000, 32'(hits));
  endtask
  task automatic wk(input logic [12:0] req, input nipc_mode_t m,
      input logic exp);
    irq_req <= req;
    halt_mode <= m;
    repeat (3) @(posedge pclk);
    cmp("wake", 32'(exp), 32'(wake));
  endtask

  task automatic t_regs();
    rd(OFS_LEVEL0, 32'h0000_00FF);
    rd(OFS_LEVEL3, 32'h0000_00FF);
    rd(OFS_CC, 32'h0000_0028);
    rd(8'h40, 32'h0000_0000);
    cmp("slverr", 32'h0000_0001, 32'(last_err));
    wr(OFS_LEVEL0, 32'h0000_00CF);
    wr(OFS_LEVEL0, 32'h0000_0064);
    rd(OFS_LEVEL0, 32'h0000_0044);
    wr(OFS_LEVEL3, 32'h0000_0000);
    rd(OFS_LEVEL3, 32'h0000_00F0);
    wr(OFS_LEVEL0, 32'h0000_00FF);
    wr(OFS_LEVEL3, 32'h0000_00FF);
    pstrb <= 4'hE;
    wr(OFS_LEVEL0, 32'h0000_0000);
    pstrb <= 4'hF;
    rd(OFS_LEVEL0, 32'h0000_00FF);
  endtask
  task automatic t_instr();
    step(7'h40, 8'h00, LVL0);
    step(7'h20, 8'h00, LVL3);
    step(7'h04, 8'h08, LVL1);
    step(7'h04, 8'h00, LVL2);
    step(7'h10, 8'h00, LVL0);
    step(7'h02, 8'h28, LVL3);
    step(7'h08, 8'h00, LVL0);
  endtask
  task automatic t_entry();
    wr(OFS_LEVEL1, 32'h0000_00FC);
    instr_boundary <= 1'b1;
    irq_req <= 13'h0010;
    wait_enter(16'hFFF2, LVL2);
    cmp("vec_num", 32'h0000_0004, 32'(entry.vec_num));
    stack_cycles <= 4'h5;
    irq_req <= 13'h0014;
    wait_enter(16'hFFF6, LVL3);
    irq_req <= 13'h0000;
    step(7'h02, 8'h00, LVL2);
    irq_req <= 13'h0010;
    wr(OFS_LEVEL1, 32'h0000_00FF);
    wait_enter(16'hFFF2, LVL3);
    irq_req <= 13'h0000;
  endtask
  task automatic t_arbit();
    wr(OFS_LEVEL1, 32'h0000_00F7);
    step(7'h02, 8'h20, LVL0);
    irq_req <= 13'h1020;
    wait_enter(16'hFFE2, LVL3);
    irq_req <= 13'h0000;
    step(7'h02, 8'h20, LVL0);
    irq_req <= 13'h000C;
    wait_enter(16'hFFF6, LVL3);
    irq_req <= 13'h0000;
    step(7'h02, 8'h20, LVL0);
    quiet(13'h0002);
    step(7'h20, 8'h00, LVL3);
    quiet(13'h0012);
    rd(OFS_PEND, 32'h0000_0012);
    pulse(7'h01, 8'h00);
    wait_enter(VEC_TRAP, LVL3);
    irq_req <= 13'h0000;
    instr_boundary <= 1'b0;
  endtask
  task automatic t_wake();
    step(7'h40, 8'h00, LVL0);
    wk(13'h0001, MODE_HALT, 1'b0);
    wk(13'h0011, MODE_HALT, 1'b1);
    wk(13'h0080, MODE_HALT, 1'b0);
    wk(13'h0080, MODE_ACTIVE_HALT, 1'b1);
    wk(13'h0001, MODE_AUTO_WAKEUP, 1'b1);
    wk(13'h0000, MODE_RUN, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_instr();
    t_entry();
    t_arbit();
    t_wake();
    summarize();
  end
endmodule // nested_interrupt_priority_ctrl_tb
